// file: rtl/hsse_regs.svh
// constants for the halt, subtract and nibble-exchange execute block
`ifndef HSSE_REGS_SVH
`define HSSE_REGS_SVH
`define HSSE_OP_HALT 12'h003
`define HSSE_SUB_TOP 6'h02
`define HSSE_SWP_TOP 6'h0e
`define HSSE_OP_TOP_LSB 6
`define HSSE_DEST_BIT 5
`define HSSE_ADDR_MSB 4
`define HSSE_ACC_RST 8'h00
`define HSSE_WDOG_CLR 8'h00
`define HSSE_PRESC_CLR 8'h00
`endif

// file: rtl/hsse_pkg.sv
// types for the halt, subtract and nibble-exchange execute block
package hsse_pkg;
  typedef enum logic [1:0] {HSSE_RUN, HSSE_HALTED} hsse_state_t;
  typedef enum logic [1:0] {HSSE_NONE, HSSE_HALT, HSSE_SUB, HSSE_SWAP} hsse_op_t;
endpackage

// file: rtl/hsse_alu.sv
// combinational subtract and nibble-exchange datapath
`timescale 1ns/10ps
module hsse_alu #(
  parameter int W = 8
) (
  input wire logic [W-1:0] file_val,
  input wire logic [W-1:0] acc_val,
  output logic [W-1:0] diff,
  output logic diff_carry,
  output logic diff_half,
  output logic diff_zero,
  output logic [W-1:0] swapped
);
  logic [W:0] full;
  logic [4:0] low;
  // borrow-free carry: file + ~acc + 1 carries out exactly when file >= acc
  assign full = {1'b0, file_val} + {1'b0, ~acc_val} + {{W{1'b0}}, 1'b1};
  assign low = {1'b0, file_val[3:0]} + {1'b0, ~acc_val[3:0]} + 5'h01;
  assign diff = full[W-1:0];
  assign diff_carry = full[W];
  assign diff_half = low[4];
  assign diff_zero = (full[W-1:0] == '0);
  assign swapped = {file_val[W/2-1:0], file_val[W-1:W/2]};
endmodule

// file: rtl/hsse_exec.sv
// execute stage for halt, subtract and nibble-exchange instructions
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "hsse_regs.svh"
module hsse_exec import hsse_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  input wire logic [W-1:0] file_rdata,
  input wire logic wake,
  output logic [W-1:0] acc_q,
  output logic [W-1:0] file_wdata_q,
  output logic [4:0] file_waddr_q,
  output logic file_we_q,
  output logic carry_flag_q,
  output logic half_carry_flag_q,
  output logic zero_flag_q,
  output logic watchdog_expiry_flag_n_q,
  output logic low_power_entry_flag_n_q,
  output logic watchdog_clear_q,
  output logic osc_run_q,
  output logic halted,
  output logic instr_ready
);
  hsse_state_t state_q;
  logic [W-1:0] diff;
  logic [W-1:0] swapped;
  logic diff_carry;
  logic diff_half;
  logic diff_zero;
  logic wake_s1_q;
  logic wake_s2_q;
  logic take;
  logic dest_file;
  hsse_op_t op;
  logic [W-1:0] result;

  hsse_alu #(.W(W)) u_alu (
    .file_val(file_rdata),
    .acc_val(acc_q),
    .diff(diff),
    .diff_carry(diff_carry),
    .diff_half(diff_half),
    .diff_zero(diff_zero),
    .swapped(swapped)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode; wake comes from the pin side, so it is synchronised first
  assign halted = (state_q == HSSE_HALTED);
  assign instr_ready = !halted;
  assign take = clk_en && instr_valid && !halted;
  assign dest_file = instr[`HSSE_DEST_BIT];
  // halt is matched on the whole word before the top-bit patterns, so no field can alias it
  assign op = (instr == `HSSE_OP_HALT) ? HSSE_HALT :
              (instr[11:`HSSE_OP_TOP_LSB] == `HSSE_SUB_TOP) ? HSSE_SUB :
              (instr[11:`HSSE_OP_TOP_LSB] == `HSSE_SWP_TOP) ? HSSE_SWAP : HSSE_NONE;
  // swap is the fallback result; halt and unknown codes never write, so it does no harm
  assign result = (op == HSSE_SUB) ? diff : swapped;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else if (clk_en) begin
      wake_s1_q <= wake;
      wake_s2_q <= wake_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // halt state; only a wake leaves it, other instructions are ignored meanwhile
  // the run flag is a register so the oscillator control never sees a decode glitch
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= HSSE_RUN;
      osc_run_q <= 1'b1;
    end else if (clk_en) begin
      case (state_q)
        HSSE_RUN: begin
          if (take && op == HSSE_HALT) begin
            state_q <= HSSE_HALTED;
            osc_run_q <= 1'b0;
          end
        end
        default: begin
          if (wake_s2_q) begin
            state_q <= HSSE_RUN;
            osc_run_q <= 1'b1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power status flags; reset values are set by the wider reset logic, here one
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      watchdog_expiry_flag_n_q <= 1'b1;
      low_power_entry_flag_n_q <= 1'b1;
      watchdog_clear_q <= 1'b0;
    end else if (clk_en) begin
      watchdog_clear_q <= take && op == HSSE_HALT;
      if (take && op == HSSE_HALT) begin
        watchdog_expiry_flag_n_q <= 1'b1;
        low_power_entry_flag_n_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // arithmetic flags; nibble exchange leaves them untouched
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      carry_flag_q <= 1'b0;
      half_carry_flag_q <= 1'b0;
      zero_flag_q <= 1'b0;
    end else if (clk_en && take && op == HSSE_SUB) begin
      carry_flag_q <= diff_carry;
      half_carry_flag_q <= diff_half;
      zero_flag_q <= diff_zero;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result steering to accumulator or file register
  // the write strobe falls on every enabled cycle, so each file write pulses it for one enabled cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      acc_q <= `HSSE_ACC_RST;
      file_wdata_q <= '0;
      file_waddr_q <= 5'h00;
      file_we_q <= 1'b0;
    end else if (clk_en) begin
      file_we_q <= 1'b0;
      if (take && (op == HSSE_SUB || op == HSSE_SWAP)) begin
        if (dest_file) begin
          file_we_q <= 1'b1;
          file_wdata_q <= result;
          file_waddr_q <= instr[`HSSE_ADDR_MSB:0];
        end else begin
          acc_q <= result;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks; disabled while the enable is low, since every register is frozen then
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b || !clk_en);

  // halt entry and the halted state
  a_halt_expiry: assert property (take && op == HSSE_HALT |=> watchdog_expiry_flag_n_q)
    else $error("halt did not set expiry flag");
  a_halt_lowpow: assert property (take && op == HSSE_HALT |=> !low_power_entry_flag_n_q)
    else $error("halt did not clear low-power flag");
  a_halt_wdclr: assert property (take && op == HSSE_HALT |=> watchdog_clear_q)
    else $error("halt did not clear watchdog");
  a_halt_stop: assert property (take && op == HSSE_HALT |=> halted && !osc_run_q && !instr_ready)
    else $error("halt did not stop core");
  a_halt_quiet: assert property (halted && !wake_s2_q |=> !file_we_q && $stable(acc_q))
    else $error("activity while halted");
  a_halt_hold: assert property (halted && !wake_s2_q |=> halted && !osc_run_q && !instr_ready)
    else $error("halt left without wake");
  a_wake_exit: assert property (halted && wake_s2_q |=> !halted && osc_run_q && instr_ready)
    else $error("wake did not restart core");

  // subtract
  a_sub_result: assert property (take && op == HSSE_SUB && !dest_file |=>
    acc_q == $past(file_rdata) - $past(acc_q))
    else $error("subtract result wrong");
  a_sub_file: assert property (take && op == HSSE_SUB && dest_file |=>
    file_we_q && file_wdata_q == $past(file_rdata) - $past(acc_q) && file_waddr_q == $past(instr[`HSSE_ADDR_MSB:0]))
    else $error("subtract file write wrong");
  a_sub_keep: assert property (take && op == HSSE_SUB && dest_file |=> $stable(acc_q))
    else $error("subtract to file changed accumulator");
  a_sub_carry: assert property (take && op == HSSE_SUB |=>
    carry_flag_q == ($past(file_rdata) >= $past(acc_q)))
    else $error("subtract carry wrong");
  a_sub_half: assert property (take && op == HSSE_SUB |=>
    half_carry_flag_q == ($past(file_rdata[3:0]) >= $past(acc_q[3:0])))
    else $error("subtract half-carry wrong");
  a_sub_zero: assert property (take && op == HSSE_SUB |=>
    zero_flag_q == ($past(file_rdata) == $past(acc_q)))
    else $error("subtract zero wrong");

  // nibble exchange
  a_swap_flags: assert property (take && op == HSSE_SWAP |=>
    $stable(carry_flag_q) && $stable(zero_flag_q) && $stable(half_carry_flag_q))
    else $error("swap changed flags");
  a_swap_file: assert property (take && op == HSSE_SWAP && dest_file |=>
    file_we_q && file_wdata_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap file write wrong");
  a_swap_acc: assert property (take && op == HSSE_SWAP && !dest_file |=>
    !file_we_q && acc_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap accumulator write wrong");
  a_swap_keep: assert property (take && op == HSSE_SWAP && dest_file |=> $stable(acc_q))
    else $error("swap to file changed accumulator");

  // main scenarios
  c_halt: cover property (take && op == HSSE_HALT ##1 halted);
  c_sub_borrow: cover property (take && op == HSSE_SUB && !diff_carry);
  c_sub_file: cover property (take && op == HSSE_SUB && dest_file);
  c_swap_file: cover property (take && op == HSSE_SWAP && dest_file);
  c_wake: cover property (halted ##1 !halted);
endmodule

// file: verif/tb_halt_subtract_swap_exec.sv
// self-checking bench for the halt, subtract and nibble-exchange execute block
`timescale 1ns/10ps
`include "hsse_regs.svh"
module tb_halt_subtract_swap_exec;
  typedef struct {int due; logic h; logic [30:0] v;} hsse_note_t;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b0;
  logic instr_valid = 1'b0;
  logic wake = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] acc_q, file_wdata_q;
  logic [4:0] file_waddr_q;
  logic file_we_q, carry_flag_q, half_carry_flag_q, zero_flag_q, watchdog_clear_q, osc_run_q;
  logic watchdog_expiry_flag_n_q, low_power_entry_flag_n_q, halted, instr_ready;
  logic [7:0] m_acc = 8'h00;
  logic m_c, m_dc, m_z, m_wx, m_lp, m_h, m_we, m_clr;
  logic [4:0] m_wa;
  logic [7:0] m_wd;
  logic [31:0] s = 32'h90fbbe3f;
  int cyc = 0;
  int errors = 0;
  int compares = 0;
  hsse_note_t q[$];
  hsse_exec #(.W(8)) hsse_exec_inst (.clock, .rst_b, .clk_en, .instr_valid, .instr, .file_rdata, .wake,
    .acc_q, .file_wdata_q, .file_waddr_q, .file_we_q, .carry_flag_q, .half_carry_flag_q, .zero_flag_q,
    .watchdog_expiry_flag_n_q, .low_power_entry_flag_n_q, .watchdog_clear_q, .osc_run_q, .halted, .instr_ready);
  //////////////////////////////////////////////////////////////////////////////
  initial forever #4 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction
  task automatic report_and_stop();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [30:0] e);
    logic [30:0] o;
    o = {acc_q, file_we_q, file_we_q ? file_waddr_q : 5'h00, file_we_q ? file_wdata_q : 8'h00, carry_flag_q,
      half_carry_flag_q, zero_flag_q, watchdog_expiry_flag_n_q, low_power_entry_flag_n_q, watchdog_clear_q,
      osc_run_q, halted, instr_ready};
    compares++;
    if (o !== e) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, o, e);
    end
  endtask
  // one clock edge per call, enabled only when e is set; the note predicts the outputs after the next edge
  task automatic step(input logic r, input logic e, input logic v, input logic [11:0] i, input logic [7:0] f);
    logic [8:0] d;
    logic [4:0] hb;
    logic [7:0] res;
    logic tk, sub, hlt;
    @(posedge clock);
    rst_b <= r;
    clk_en <= e;
    instr_valid <= v;
    instr <= i;
    file_rdata <= f;
    tk = r & e & v & !m_h;
    sub = i[11:`HSSE_OP_TOP_LSB] == `HSSE_SUB_TOP;
    hlt = tk && i == `HSSE_OP_HALT;
    d = {1'b0, f} - {1'b0, m_acc};
    hb = {1'b0, f[3:0]} - {1'b0, m_acc[3:0]};
    res = sub ? d[7:0] : {f[3:0], f[7:4]};
    if (!r) begin
      {m_acc, m_c, m_dc, m_z, m_wx, m_lp, m_h} = {8'h00, 6'h06};
      {m_we, m_wa, m_wd, m_clr} = 15'h0000;
    end else if (e) begin
      // a low enable freezes the strobes too, so they are only recomputed on enabled edges
      m_we = 1'b0;
      m_clr = hlt;
      if (hlt) begin
        {m_wx, m_lp, m_h} = 3'h5;
      end else if (tk && (sub || i[11:`HSSE_OP_TOP_LSB] == `HSSE_SWP_TOP)) begin
        if (sub) begin
          {m_c, m_dc, m_z} = {!d[8], !hb[4], d[7:0] == 8'h00};
        end
        if (i[`HSSE_DEST_BIT]) begin
          {m_we, m_wa, m_wd} = {1'b1, i[4:0], res};
        end else begin
          m_acc = res;
        end
      end
    end
    q.push_back('{cyc + 2, hlt, {m_acc, m_we, m_we ? m_wa : 5'h00, m_we ? m_wd : 8'h00, m_c, m_dc, m_z, m_wx,
      m_lp, m_clr, !m_h, m_h, !m_h}});
  endtask
  task automatic wake_up();
    int n;
    @(posedge clock);
    wake <= 1'b1;
    clk_en <= 1'b1;
    instr_valid <= 1'b0;
    n = 0;
    while (halted !== 1'b0 && n < 10) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 10) begin
      errors++;
      $display("BAD t=%0t no exit from halt", $time);
    end
    @(posedge clock);
    wake <= 1'b0;
    m_h = 1'b0;
    // let the synchroniser drain so a stale wake cannot end the next halt
    repeat (3) step(1'b1, 1'b1, 1'b0, 12'h000, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      errors++;
      report_and_stop();
    end
  end
  initial forever begin
    hsse_note_t n;
    @(posedge clock);
    #1;
    if (q.size() > 0 && q[0].due == cyc) begin
      n = q.pop_front();
      if (n.h) begin
        cmp(n.v);
      end else begin
        cmp(n.v);
      end
    end
  end
  initial begin
    logic [11:0] op;
    repeat (5) step(1'b0, 1'b1, 1'b0, 12'h000, 8'h00);
    for (int k = 0; k < 600; k++) begin
      s = lfsr(s);
      case (s[1:0])
        2'd0: op = {`HSSE_SUB_TOP, s[9:4]};
        2'd1: op = {`HSSE_SWP_TOP, s[9:4]};
        2'd2: op = s[21:10];
        default: op = s[4:2] == 3'h0 ? `HSSE_OP_HALT : {`HSSE_SUB_TOP, s[9:4]};
      endcase
      step(k != 300, s[25:23] != 3'h0, s[22:21] != 2'h0, op, s[26] ? m_acc : s[31:24]);
      if (m_h && s[20:18] == 3'h0) begin
        wake_up();
      end
    end
    repeat (3) step(1'b1, 1'b1, 1'b0, 12'h000, 8'h00);
    // let the last notes come due before judging
    repeat (2) @(posedge clock);
    #2;
    if (q.size() != 0) begin
      errors++;
      $display("BAD t=%0t %0d results never seen", $time, q.size());
    end
    report_and_stop();
  end
endmodule
